/* File: rtl/fsv_sequencer.sv */
// internal-verify sequencer of the flash self-programming unit
// assumes cpu register writes arrive as one-cycle strobes, halt as a pulse
`timescale 1ns/1ps
`default_nettype none
`include "fsv_params.svh"

// Behaviour
// R1 - command 01H selects whole-block verify
// R2 - command 02H selects verify of a chosen range in one block
// R3 - software sets low pointer to 00H for whole-block verify
// R4 - software sets low compare to FFH for whole-block verify
// R5 - software sets low pointer to start, low compare to end for range verify
// R6 - software writes equal block number to block pointer and block compare
// R7 - software clears the status register before launching
// R8 - software restarts the watchdog with ACH when it is used
// R9 - halt launches the operation; cpu resumes after completion
// R10 - status bit 1 flags voltage error, bit 2 write/erase error
// R11 - step low address pointer to compare inclusive; flag any failing location
module fsv_sequencer #(
	parameter int BLK_W = 8,
	parameter int LOW_W = 8
) (
	input  wire logic                  clk,
	input  wire logic                  rstn,
	input  wire logic                  cmdWe,
	input  wire logic [7:0]            cmdData,
	input  wire logic                  blockPtrWe,
	input  wire logic                  blockCmpWe,
	input  wire logic [BLK_W-1:0]      blockData,
	input  wire logic                  addrPtrWe,
	input  wire logic                  addrCmpWe,
	input  wire logic [LOW_W-1:0]      addrData,
	input  wire logic                  statusWe,
	input  wire logic [7:0]            statusData,
	input  wire logic                  haltExec,
	input  wire logic                  voltageOk,
	output logic                       flashRdEn,
	output logic [BLK_W+LOW_W-1:0]     flashAddr,
	input  wire logic                  flashRdValid,
	input  wire logic                  flashRdOk,
	output logic [7:0]                 flash_command_reg,
	output logic [BLK_W-1:0]           block_pointer_high,
	output logic [BLK_W-1:0]           block_compare_high,
	output logic [LOW_W-1:0]           address_pointer_low,
	output logic [LOW_W-1:0]           address_compare_low,
	output logic [7:0]                 flash_status_reg,
	output logic                       busy,
	output logic                       cpuResume
);
	fsv_pkg::fsv_state_t state;
	fsv_pkg::fsv_state_t next_state;
	logic [LOW_W-1:0]    curLow;
	logic                cmdKnown;
	logic                setupBad;
	logic                setVolt;
	logic                setWe;
	logic                lastLoc;

	fsv_check_if #(.BLK_W(BLK_W), .LOW_W(LOW_W)) chk ();

	fsv_verify_unit #(.BLK_W(BLK_W), .LOW_W(LOW_W)) u_unit (
		.clk          (clk),
		.rstn         (rstn),
		.chk          (chk.unit),
		.flashRdEn    (flashRdEn),
		.flashAddr    (flashAddr),
		.flashRdValid (flashRdValid),
		.flashRdOk    (flashRdOk)
	);

	assign cmdKnown  = (flash_command_reg == `FSV_CMD_VERIFY_BLOCK) ||
		(flash_command_reg == `FSV_CMD_VERIFY_RANGE); // R1 R2
	// block pair must match and range must not run backwards
	assign setupBad  = (block_pointer_high != block_compare_high) ||
		(address_pointer_low > address_compare_low); // R6 R5
	assign lastLoc   = (curLow == address_compare_low); // R11
	assign busy      = (state != fsv_pkg::FSV_IDLE);
	assign cpuResume = (state == fsv_pkg::FSV_DONE); // R9
	assign chk.req   = (state == fsv_pkg::FSV_ISSUE);
	assign chk.blk   = block_pointer_high;
	assign chk.low   = curLow;

	// =========================================================
	// cpu-written setup registers, frozen while busy
	always_ff @(posedge clk) begin
		if (!rstn) begin
			flash_command_reg   <= `FSV_REG_RESET;
			block_pointer_high  <= '0;
			block_compare_high  <= '0;
			address_pointer_low <= '0;
			address_compare_low <= '0;
		end else if (!busy) begin
			if (cmdWe)
				flash_command_reg <= cmdData;
			if (blockPtrWe)
				block_pointer_high <= blockData;
			if (blockCmpWe)
				block_compare_high <= blockData;
			if (addrPtrWe)
				address_pointer_low <= addrData;
			if (addrCmpWe)
				address_compare_low <= addrData;
		end
	end

	// =========================================================
	// sequence control
	always_comb begin
		next_state = state;
		case (state)
			fsv_pkg::FSV_IDLE: begin
				if (haltExec)
					next_state = fsv_pkg::FSV_CHECK; // R9
			end
			fsv_pkg::FSV_CHECK: begin
				if (!cmdKnown || setupBad || !voltageOk)
					next_state = fsv_pkg::FSV_DONE;
				else
					next_state = fsv_pkg::FSV_ISSUE; // R1 R2
			end
			fsv_pkg::FSV_ISSUE: begin
				// supply loss aborts here too, not one cycle late
				if (!voltageOk)
					next_state = fsv_pkg::FSV_DONE; // R10
				else
					next_state = fsv_pkg::FSV_WAIT;
			end
			fsv_pkg::FSV_WAIT: begin
				if (!voltageOk)
					next_state = fsv_pkg::FSV_DONE;
				else if (chk.done && lastLoc)
					next_state = fsv_pkg::FSV_DONE; // R11
				else if (chk.done)
					next_state = fsv_pkg::FSV_ISSUE; // R11
			end
			fsv_pkg::FSV_DONE: begin
				next_state = fsv_pkg::FSV_IDLE;
			end
			default: begin
				next_state = fsv_pkg::FSV_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn)
			state <= fsv_pkg::FSV_IDLE;
		else
			state <= next_state;
	end

	// =========================================================
	// location walk
	always_ff @(posedge clk) begin
		if (!rstn)
			curLow <= '0;
		else if (state == fsv_pkg::FSV_CHECK)
			curLow <= address_pointer_low; // R11
		else if (state == fsv_pkg::FSV_WAIT && chk.done && !lastLoc)
			curLow <= curLow + 1'b1; // R11
	end

	// =========================================================
	// status flags: hardware set beats a cpu write in the same cycle
	assign setVolt = busy && !voltageOk; // R10
	assign setWe   = (state == fsv_pkg::FSV_CHECK && cmdKnown && setupBad) ||
		(state == fsv_pkg::FSV_WAIT && chk.done && chk.fail); // R10 R11

	always_ff @(posedge clk) begin
		if (!rstn) begin
			flash_status_reg <= `FSV_REG_RESET;
		end else begin
			if (statusWe)
				flash_status_reg <= statusData & `FSV_STATUS_MASK;
			if (setVolt)
				flash_status_reg[`FSV_BIT_VOLT_ERR] <= 1'b1; // R10
			if (setWe)
				flash_status_reg[`FSV_BIT_WE_ERR] <= 1'b1; // R10
		end
	end

	// =========================================================
	// checks
	a_launch_halt: assert property (@(posedge clk) disable iff (!rstn) // R9
		state == fsv_pkg::FSV_IDLE && haltExec |=> busy ##1 busy)
		else $error("halt did not launch the sequence");

	a_resume_once: assert property (@(posedge clk) disable iff (!rstn) // R9
		cpuResume |=> !cpuResume && !busy)
		else $error("resume not a single cycle ending the run");

	a_block_start: assert property (@(posedge clk) disable iff (!rstn) // R1
		state == fsv_pkg::FSV_CHECK && voltageOk && !setupBad &&
		flash_command_reg == `FSV_CMD_VERIFY_BLOCK
		|=> state == fsv_pkg::FSV_ISSUE && curLow == $past(address_pointer_low))
		else $error("block verify did not start at pointer");

	a_range_start: assert property (@(posedge clk) disable iff (!rstn) // R2
		state == fsv_pkg::FSV_CHECK && voltageOk && !setupBad &&
		flash_command_reg == `FSV_CMD_VERIFY_RANGE
		|=> state == fsv_pkg::FSV_ISSUE ##1 chk.low == address_pointer_low)
		else $error("range verify did not start at pointer");

	a_addr_step: assert property (@(posedge clk) disable iff (!rstn) // R11
		state == fsv_pkg::FSV_WAIT && voltageOk && chk.done && !lastLoc
		|=> state == fsv_pkg::FSV_ISSUE && curLow == $past(curLow) + 1'b1)
		else $error("address did not step by one");

	a_range_end: assert property (@(posedge clk) disable iff (!rstn) // R11
		state == fsv_pkg::FSV_WAIT && chk.done && lastLoc
		|=> cpuResume ##1 !busy)
		else $error("walk did not end at compare value");

	a_fail_flag: assert property (@(posedge clk) disable iff (!rstn) // R10
		state == fsv_pkg::FSV_WAIT && chk.done && chk.fail
		|=> flash_status_reg[`FSV_BIT_WE_ERR])
		else $error("failed location not flagged");

	a_volt_flag: assert property (@(posedge clk) disable iff (!rstn) // R10
		busy && !voltageOk |=> flash_status_reg[`FSV_BIT_VOLT_ERR] ##1 !busy)
		else $error("voltage error not flagged or run not ended");

	a_flag_sticky: assert property (@(posedge clk) disable iff (!rstn) // R10
		flash_status_reg[`FSV_BIT_WE_ERR] && !statusWe
		|=> flash_status_reg[`FSV_BIT_WE_ERR])
		else $error("write erase flag dropped without a write");
endmodule // fsv_sequencer
`default_nettype wire

/* File: pkg/fsv_params.svh */
// constants for the flash self-program verify sequencer
// included by the sequencer module; definitions only
`ifndef FSV_PARAMS_SVH
`define FSV_PARAMS_SVH

`define FSV_CMD_VERIFY_BLOCK 8'h01
`define FSV_CMD_VERIFY_RANGE 8'h02
`define FSV_BIT_VOLT_ERR     1
`define FSV_BIT_WE_ERR       2
`define FSV_REG_RESET        8'h00
`define FSV_STATUS_MASK      8'h06

`endif

/* File: pkg/fsv_pkg.sv */
// types shared by the verify sequencer modules
// assumes fsv_params.svh is on the include path
`default_nettype none
package fsv_pkg;
	typedef enum logic [2:0] {
		FSV_IDLE  = 3'b000,
		FSV_CHECK = 3'b001,
		FSV_ISSUE = 3'b010,
		FSV_WAIT  = 3'b011,
		FSV_DONE  = 3'b100
	} fsv_state_t;
endpackage
`default_nettype wire

/* File: pkg/fsv_check_if.sv */
// one-location check request between sequencer and verify unit
// assumes both ends share clk
`timescale 1ns/1ps
`default_nettype none
interface fsv_check_if #(parameter int BLK_W = 8, parameter int LOW_W = 8);
	logic             req;
	logic [BLK_W-1:0] blk;
	logic [LOW_W-1:0] low;
	logic             done;
	logic             fail;
	modport seq  (output req, output blk, output low, input done, input fail);
	modport unit (input req, input blk, input low, output done, output fail);
endinterface
`default_nettype wire

/* File: rtl/fsv_verify_unit.sv */
// checks one flash location with the array's verify read port
// assumes the array answers each read with rdValid, holding rdOk with it
`timescale 1ns/1ps
`default_nettype none
module fsv_verify_unit #(
	parameter int BLK_W = 8,
	parameter int LOW_W = 8
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	fsv_check_if.unit             chk,
	output logic                  flashRdEn,
	output logic [BLK_W+LOW_W-1:0] flashAddr,
	input  wire logic             flashRdValid,
	input  wire logic             flashRdOk
);
	// =========================================================
	// read request held until the array answers
	always_ff @(posedge clk) begin
		if (!rstn) begin
			flashRdEn <= 1'b0;
			flashAddr <= '0;
		end else if (flashRdEn && flashRdValid) begin
			flashRdEn <= 1'b0;
		end else if (chk.req && !flashRdEn) begin
			flashRdEn <= 1'b1;
			flashAddr <= {chk.blk, chk.low};
		end
	end

	// =========================================================
	// answer
	always_ff @(posedge clk) begin
		if (!rstn) begin
			chk.done <= 1'b0;
			chk.fail <= 1'b0;
		end else begin
			chk.done <= flashRdEn && flashRdValid;
			chk.fail <= flashRdEn && flashRdValid && !flashRdOk; // R11
		end
	end

	a_read_hold: assert property (@(posedge clk) disable iff (!rstn) // R11
		flashRdEn && !flashRdValid |=> flashRdEn && $stable(flashAddr))
		else $error("verify read dropped before answer");
endmodule // fsv_verify_unit
`default_nettype wire

/* File: bench/testbench.sv */
// self-checking bench for the flash verify sequencer
// assumes fsv_params.svh on the include path; bench answers the array's verify reads
`timescale 1ns/1ps
`default_nettype none
module testbench;
	typedef struct {
		logic [7:0] cmd, blk, blkc, lo, hi;
		logic [8:0] failLow;
		logic [7:0] st;
		int         reads;
	} fsv_tb_row_t;
	logic        clk, rstn, cmdWe, blockPtrWe, blockCmpWe, addrPtrWe, addrCmpWe;
	logic        statusWe, haltExec, voltageOk, flashRdEn, flashRdValid, flashRdOk;
	logic        busy, cpuResume;
	logic [7:0]  cmdData, blockData, addrData, statusData, cmdReg, blkPtr, blkCmp;
	logic [7:0]  addrPtr, addrCmp, status, curBlk, expLow;
	logic [8:0]  failLow;
	logic [15:0] flashAddr;
	int          miscompares, check_count, rdCount;
	fsv_tb_row_t rows[7];
	fsv_sequencer i_fsv_sequencer (.clk(clk), .rstn(rstn), .cmdWe(cmdWe), .cmdData(cmdData),
		.blockPtrWe(blockPtrWe), .blockCmpWe(blockCmpWe), .blockData(blockData),
		.addrPtrWe(addrPtrWe), .addrCmpWe(addrCmpWe), .addrData(addrData),
		.statusWe(statusWe), .statusData(statusData), .haltExec(haltExec),
		.voltageOk(voltageOk), .flashRdEn(flashRdEn), .flashAddr(flashAddr),
		.flashRdValid(flashRdValid), .flashRdOk(flashRdOk), .flash_command_reg(cmdReg),
		.block_pointer_high(blkPtr), .block_compare_high(blkCmp),
		.address_pointer_low(addrPtr), .address_compare_low(addrCmp),
		.flash_status_reg(status), .busy(busy), .cpuResume(cpuResume));
	// ====================
	// clock and array model
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// slow answer: valid one cycle after the read request
	always @(posedge clk) begin
		flashRdValid <= flashRdEn && !flashRdValid;
		flashRdOk    <= {1'b0, flashAddr[7:0]} !== failLow;
		if (flashRdEn === 1'b1 && flashRdValid === 1'b1) begin
			chk(flashAddr, {curBlk, expLow});
			expLow  <= expLow + 8'h01;
			rdCount <= rdCount + 1;
		end
	end
	// ====================
	// tasks
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		if (miscompares == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic setup(input fsv_tb_row_t r);
		@(posedge clk);
		{cmdWe, blockPtrWe, addrPtrWe, statusWe} <= 4'hF;
		cmdData    <= r.cmd;
		blockData  <= r.blk;
		addrData   <= r.lo;
		statusData <= 8'h00;
		@(posedge clk);
		{cmdWe, blockPtrWe, addrPtrWe, statusWe, blockCmpWe, addrCmpWe} <= 6'h03;
		blockData <= r.blkc;
		addrData  <= r.hi;
		@(posedge clk);
		{blockCmpWe, addrCmpWe} <= 2'h0;
		@(negedge clk);
		chk({cmdReg, blkPtr, blkCmp, addrPtr, addrCmp}, {r.cmd, r.blk, r.blkc, r.lo, r.hi});
		curBlk  = r.blk;
		expLow  = r.lo;
		failLow = r.failLow;
		rdCount = 0;
	endtask
	task automatic launch();
		int n;
		n = 0;
		@(posedge clk) haltExec <= 1'b1;
		@(posedge clk) haltExec <= 1'b0;
		do begin
			@(negedge clk);
			n++;
		end while (cpuResume !== 1'b1 && n < 3000);
		if (n >= 3000) begin
			miscompares++;
			report_and_stop();
		end
		chk(busy, 1'b1);
		@(negedge clk);
		chk(busy, 1'b0);
	endtask
	// ====================
	// main sequence
	initial begin
		rows[0] = '{8'h01, 8'h07, 8'h07, 8'h00, 8'hFF, 9'h100, 8'h00, 256};
		rows[1] = '{8'h02, 8'h03, 8'h03, 8'h10, 8'h12, 9'h011, 8'h04, 3};
		rows[2] = '{8'h02, 8'h05, 8'h05, 8'h20, 8'h20, 9'h100, 8'h00, 1};
		rows[3] = '{8'h03, 8'h05, 8'h05, 8'h00, 8'h02, 9'h100, 8'h00, 0};
		rows[4] = '{8'h01, 8'h07, 8'h06, 8'h00, 8'hFF, 9'h100, 8'h04, 0};
		rows[5] = '{8'h02, 8'h02, 8'h02, 8'h30, 8'h2F, 9'h100, 8'h04, 0};
		rows[6] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'hFF, 9'h0FF, 8'h04, 256};
		{rstn, cmdWe, blockPtrWe, blockCmpWe, addrPtrWe, addrCmpWe, statusWe, haltExec} = 8'h00;
		{cmdData, blockData, addrData, statusData} = 32'h0000_0000;
		{flashRdValid, flashRdOk, voltageOk} = 3'h1;
		{miscompares, check_count, rdCount} = 96'h0;
		{curBlk, expLow, failLow} = 25'h0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk({cmdReg, blkPtr, blkCmp, addrPtr, addrCmp}, 16'h0000);
		chk({status, busy, cpuResume, flashRdEn}, 16'h0000);
		foreach (rows[i]) begin
			setup(rows[i]);
			launch();
			chk(status, rows[i].st);
			chk(rdCount, rows[i].reads);
		end
		// supply drop mid-walk, setup write while busy
		setup(rows[0]);
		@(posedge clk) haltExec <= 1'b1;
		@(posedge clk) haltExec <= 1'b0;
		repeat (20) @(posedge clk);
		voltageOk <= 1'b0;
		cmdWe     <= 1'b1;
		cmdData   <= 8'h02;
		@(posedge clk) cmdWe <= 1'b0;
		repeat (8) @(negedge clk);
		chk(busy, 1'b0);
		chk(status & 8'h02, 8'h02);
		chk(cmdReg, 8'h01);
		@(posedge clk);
		voltageOk  <= 1'b1;
		statusWe   <= 1'b1;
		statusData <= 8'hFF;
		@(posedge clk) statusData <= 8'h00;
		@(negedge clk);
		chk(status, 8'h06);
		@(posedge clk) statusWe <= 1'b0;
		@(negedge clk);
		chk(status, 8'h00);
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire
